// ===== verilog/dpram_twin_port_array.sv
`timescale 1ns/10ps
`include "dpram_cfg.svh"
module dpram_twin_port_array #(
  parameter dpram_pkg::dpram_mode_type PORT_A_MODE = dpram_pkg::DPRAM_MODE_RW,
  parameter dpram_pkg::dpram_mode_type PORT_B_MODE = dpram_pkg::DPRAM_MODE_RW
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire dpram_pkg::dpram_a_req_type reqA,
  input wire dpram_pkg::dpram_b_req_type reqB,
  output logic [`DPRAM_A_WIDTH-1:0] dataOutA,
  output logic [`DPRAM_B_WIDTH-1:0] dataOutB
);
  import dpram_pkg::*;

  // Port capability flags, fixed at build time
  localparam logic CAN_WRITE_A = (PORT_A_MODE == DPRAM_MODE_RW);
  localparam logic CAN_WRITE_B = (PORT_B_MODE != DPRAM_MODE_RO);
  localparam logic CAN_READ_B = (PORT_B_MODE == DPRAM_MODE_RW);

  dpram_state_type state;
  dpram_state_type next_state;

  logic riseA;
  logic fallA;
  logic weRiseA;
  logic [`DPRAM_A_WIDTH-1:0] priorWordA;
  logic riseB;
  logic fallB;
  logic weRiseB;
  logic [`DPRAM_B_WIDTH-1:0] priorWordB;

  // Separate edge trackers per port keep the ports independent
  dpram_port_edge #(
    .DW(`DPRAM_A_WIDTH)
  ) edgeA (
    .clk_sys(clk_sys),
    .rst(rst),
    .portStrobeClock(reqA.portStrobeClock),
    .writeEnableN(reqA.writeEnableN),
    .writeWord(reqA.writeWord),
    .strobeRise(riseA),
    .strobeFall(fallA),
    .writeEnableRise(weRiseA),
    .priorWord(priorWordA)
  );

  dpram_port_edge #(
    .DW(`DPRAM_B_WIDTH)
  ) edgeB (
    .clk_sys(clk_sys),
    .rst(rst),
    .portStrobeClock(reqB.portStrobeClock),
    .writeEnableN(reqB.writeEnableN),
    .writeWord(reqB.writeWord),
    .strobeRise(riseB),
    .strobeFall(fallB),
    .writeEnableRise(weRiseB),
    .priorWord(priorWordB)
  );

  // Both ports index one flat store at their own word width
  always_comb begin
    next_state = state;

    // Port A: finish a pending write first, so a new cycle may follow
    if (state.pendA && (fallA || weRiseA)) begin
      next_state.pendA = 1'b0;
      next_state.mem[int'(state.addrA) * `DPRAM_A_WIDTH +: `DPRAM_A_WIDTH]
        = priorWordA;
    end
    // Address taken only at the strobe rise; otherwise ignored
    if (riseA) begin
      next_state.addrA = reqA.addr;
      if (!reqA.writeEnableN && CAN_WRITE_A) begin
        next_state.pendA = 1'b1;
      end else begin
        next_state.pendA = 1'b0;
        next_state.dataOutA =
          state.mem[int'(reqA.addr) * `DPRAM_A_WIDTH +: `DPRAM_A_WIDTH];
      end
    end

    // Port B handled second: on a write clash its data wins on the shared bits
    if (state.pendB && (fallB || weRiseB)) begin
      next_state.pendB = 1'b0;
      next_state.mem[int'(state.addrB) * `DPRAM_B_WIDTH +: `DPRAM_B_WIDTH]
        = priorWordB;
    end
    if (riseB) begin
      next_state.addrB = reqB.addr;
      if (!reqB.writeEnableN && CAN_WRITE_B) begin
        next_state.pendB = 1'b1;
      end else begin
        next_state.pendB = 1'b0;
        // Write-only build keeps its output at the reset value
        if (CAN_READ_B) begin
          next_state.dataOutB =
            state.mem[int'(reqB.addr) * `DPRAM_B_WIDTH +: `DPRAM_B_WIDTH];
        end
      end
    end
  end

  // Reset clears control; the array is cleared too for a known start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state.mem <= '0;
      state.addrA <= '0;
      state.addrB <= '0;
      state.pendA <= `DPRAM_PEND_RST;
      state.pendB <= `DPRAM_PEND_RST;
      state.dataOutA <= '0;
      state.dataOutB <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Per-port outputs straight from flip-flops
  assign dataOutA = state.dataOutA;
  assign dataOutB = state.dataOutB;
endmodule

// ===== verilog/dpram_cfg.svh
// Summary of operation
// - The two ports run independently, meeting only on a shared location.
// - Port A is built either as a read/write port or as a read-only port.
// - Port B is built either as a read/write port or as a write-only port.
// - The port word widths may differ by a power-of-two ratio from 1 to 64.
// - Width times word count is equal for both ports, over one store.
// - Each port captures its address on the rising edge of its own strobe.
// - An address change without a strobe rising edge has no effect.
// - A read starts on the strobe rise, with no strobe pulse length needed.
// - Write data is latched at strobe fall or write enable rise, if earlier.
// - The build allows 8 to 16384 words, 1 to 64 bits, at most 16384 bits.
// - Every per-port signal carries its port letter A or B.
`ifndef DPRAM_CFG_SVH
`define DPRAM_CFG_SVH

// Port geometry: both ports span the same total bit count
`define DPRAM_A_WIDTH 16
`define DPRAM_A_DEPTH 64
`define DPRAM_A_ADDR_W 6
`define DPRAM_B_WIDTH 8
`define DPRAM_B_DEPTH 128
`define DPRAM_B_ADDR_W 7
`define DPRAM_TOTAL_BITS (`DPRAM_A_WIDTH * `DPRAM_A_DEPTH)

// Reset values
`define DPRAM_STROBE_RST 1'b0
`define DPRAM_WEN_RST 1'b1
`define DPRAM_PEND_RST 1'b0

`endif

// ===== verilog/dpram_pkg.sv
package dpram_pkg;
`include "dpram_cfg.svh"

  // Build-time port capability
  typedef enum logic [2:0] {
    DPRAM_MODE_RW = 3'h1,
    DPRAM_MODE_RO = 3'h2,
    DPRAM_MODE_WO = 3'h4
  } dpram_mode_type;

  // Port A request pins
  typedef struct packed {
    logic portStrobeClock;
    logic writeEnableN;
    logic [`DPRAM_A_ADDR_W-1:0] addr;
    logic [`DPRAM_A_WIDTH-1:0] writeWord;
  } dpram_a_req_type;

  // Port B request pins
  typedef struct packed {
    logic portStrobeClock;
    logic writeEnableN;
    logic [`DPRAM_B_ADDR_W-1:0] addr;
    logic [`DPRAM_B_WIDTH-1:0] writeWord;
  } dpram_b_req_type;

  // Whole state of the array
  typedef struct packed {
    logic [`DPRAM_TOTAL_BITS-1:0] mem;
    logic [`DPRAM_A_ADDR_W-1:0] addrA;
    logic [`DPRAM_B_ADDR_W-1:0] addrB;
    logic pendA;
    logic pendB;
    logic [`DPRAM_A_WIDTH-1:0] dataOutA;
    logic [`DPRAM_B_WIDTH-1:0] dataOutB;
  } dpram_state_type;

endpackage

// ===== verilog/dpram_port_edge.sv
`timescale 1ns/10ps
`include "dpram_cfg.svh"
module dpram_port_edge #(
  parameter int DW = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic portStrobeClock,
  input wire logic writeEnableN,
  input wire logic [DW-1:0] writeWord,
  output logic strobeRise,
  output logic strobeFall,
  output logic writeEnableRise,
  output logic [DW-1:0] priorWord
);
  import dpram_pkg::*;

  typedef struct packed {
    logic strobe;
    logic weN;
    logic [DW-1:0] word;
  } dpram_edge_state_type;

  dpram_edge_state_type state;
  dpram_edge_state_type next_state;

  // Previous samples of the port pins
  always_comb begin
    next_state.strobe = portStrobeClock;
    next_state.weN = writeEnableN;
    next_state.word = writeWord;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state.strobe <= `DPRAM_STROBE_RST;
      state.weN <= `DPRAM_WEN_RST;
      state.word <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Edges compare pin against last sample; no pulse width needed
  assign strobeRise = portStrobeClock & ~state.strobe;
  assign strobeFall = ~portStrobeClock & state.strobe;
  assign writeEnableRise = writeEnableN & ~state.weN;
  // Data as it stood just before the closing edge
  assign priorWord = state.word;
endmodule

// ===== tb/dpram_chk_properties.sv
`timescale 1ns/10ps
`include "dpram_cfg.svh"
module dpram_chk #(
  parameter dpram_pkg::dpram_mode_type A_MODE = dpram_pkg::DPRAM_MODE_RW,
  parameter dpram_pkg::dpram_mode_type B_MODE = dpram_pkg::DPRAM_MODE_RW
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire dpram_pkg::dpram_a_req_type reqA,
  input wire dpram_pkg::dpram_b_req_type reqB,
  input wire logic [`DPRAM_A_WIDTH-1:0] dataOutA,
  input wire logic [`DPRAM_B_WIDTH-1:0] dataOutB
);
  import dpram_pkg::*;
  logic pa, pb;
  // Last strobe samples, to spot rising edges
  always_ff @(posedge clk_sys) begin
    pa <= reqA.portStrobeClock;
    pb <= reqB.portStrobeClock;
  end
  wire upA = reqA.portStrobeClock & !pa;
  wire upB = reqB.portStrobeClock & !pb;
  wire qt = reqA.writeEnableN & reqB.writeEnableN;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // No write on either port, so stored data cannot move
  sequence rdA; upA && qt; endsequence
  sequence rdB; upB && qt; endsequence
  chk_a_hold: assert property (!upA |=> $stable(dataOutA))
    else $error("A out moved");
  chk_b_hold: assert property (!upB |=> $stable(dataOutB))
    else $error("B out moved");
  // A write on a read/write A build leaves the A output unchanged
  chk_a_write: assert property
    (A_MODE == DPRAM_MODE_RW && upA && !reqA.writeEnableN |=>
    $stable(dataOutA)) else $error("A wr");
  chk_b_wo_zero: assert property
    (B_MODE == DPRAM_MODE_WO |-> dataOutB == '0) else $error("B wo out");
  chk_b_write: assert property
    (upB && !reqB.writeEnableN |=> $stable(dataOutB)) else $error("B wr");
  chk_a_clear: assert property (disable iff (1'b0) rst |=> dataOutA == '0)
    else $error("A not cleared");
  chk_b_clear: assert property (disable iff (1'b0) rst |=> dataOutB == '0)
    else $error("B not cleared");
  chk_a_reread: assert property (qt ##1 rdA ##1 qt[*2] ##1
    (rdA and reqA.addr == $past(reqA.addr, 3)) |=>
    dataOutA == $past(dataOutA, 3)) else $error("A reread");
  chk_b_reread: assert property (qt ##1 rdB ##1 qt[*2] ##1
    (rdB and reqB.addr == $past(reqB.addr, 3)) |=>
    dataOutB == $past(dataOutB, 3)) else $error("B reread");
endmodule

bind dpram_twin_port_array dpram_chk #(.A_MODE(PORT_A_MODE),
  .B_MODE(PORT_B_MODE)) chkInst (.clk_sys(clk_sys), .rst(rst),
  .reqA(reqA), .reqB(reqB), .dataOutA(dataOutA), .dataOutB(dataOutB));

// ===== tb/dpram_port_driver.sv
`timescale 1ns/10ps
module dpram_port_driver #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input wire logic clk_sys,
  output logic [AW+DW+1:0] req
);
  // Idle: strobe low, write disabled
  initial req = {2'b01, {(AW + DW){1'b0}}};
  // One access; hi sets how long the strobe stays up
  task automatic op(input logic wr, input logic [AW-1:0] ad,
    input logic [DW-1:0] d, input int hi, input logic byWe);
    @(negedge clk_sys);
    req <= {1'b1, !wr, ad, d};
    repeat (hi) @(negedge clk_sys);
    if (wr && byWe) begin
      req[AW+DW] <= 1'b1;
      @(negedge clk_sys);
    end
    // Released lines carry junk, never the old value
    req <= {2'b01, ~ad, ~d};
    @(negedge clk_sys);
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
  import dpram_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  dpram_a_req_type reqA;
  dpram_b_req_type reqB;
  logic [15:0] dataOutA;
  logic [7:0] dataOutB;
  logic [7:0] mem [128];
  logic [15:0] dataOutA2;
  logic [7:0] dataOutB2;
  logic [7:0] mem2 [128];
  int miscompares = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h57;
  logic [31:0] ra, rb;
  logic [5:0] adA;
  logic [6:0] adB;
  always #5 clk_sys = ~clk_sys;
  dpram_twin_port_array DUT (.clk_sys(clk_sys), .rst(rst), .reqA(reqA),
    .reqB(reqB), .dataOutA(dataOutA), .dataOutB(dataOutB));
  // Second build on the same pins: read-only A, write-only B
  dpram_twin_port_array #(.PORT_A_MODE(DPRAM_MODE_RO),
    .PORT_B_MODE(DPRAM_MODE_WO)) DUT2 (.clk_sys(clk_sys), .rst(rst),
    .reqA(reqA), .reqB(reqB), .dataOutA(dataOutA2), .dataOutB(dataOutB2));
  dpram_port_driver #(.AW(6), .DW(16)) drvA (.clk_sys(clk_sys), .req(reqA));
  dpram_port_driver #(.AW(7), .DW(8)) drvB (.clk_sys(clk_sys), .req(reqB));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog well past the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    results();
  end
  // Two passes, so reset is also applied in mid-run
  initial begin
    for (int p = 0; p < 2; p++) begin
      @(negedge clk_sys) rst <= 1'b1;
      repeat (20) @(negedge clk_sys);
      rst <= 1'b0;
      mem = '{default: 8'h00};
      mem2 = '{default: 8'h00};
      for (int i = 0; i < 40; i++) begin
        ra = xs();
        rb = xs();
        // Ports take opposite halves, swapped each turn
        adA = {i[0], ra[4:0]};
        adB = {~i[0], rb[5:0]};
        fork
          drvA.op(ra[8], adA, ra[31:16], 1 + ra[10:9], ra[11]);
          drvB.op(rb[8], adB, rb[23:16], 1 + rb[10:9], rb[11]);
        join
        if (ra[8]) {mem[2*adA+1], mem[2*adA]} = ra[31:16];
        else check("dataOutA", dataOutA, {mem[2*adA+1], mem[2*adA]});
        if (rb[8]) mem[adB] = rb[23:16];
        else check("dataOutB", {8'h00, dataOutB}, {8'h00, mem[adB]});
        // Read-only A reads on every request; only B fills that store
        check("dataOutA2", dataOutA2, {mem2[2*adA+1], mem2[2*adA]});
        check("dataOutB2", {8'h00, dataOutB2}, 16'h0000);
        if (rb[8]) mem2[adB] = rb[23:16];
      end
    end
    // Back-to-back reads of one place on each port
    repeat (2) drvA.op(1'b0, 6'h05, 16'h0000, 1, 1'b0);
    repeat (2) drvB.op(1'b0, 7'h0A, 8'h00, 1, 1'b0);
    check("dataOutA", dataOutA, {mem[11], mem[10]});
    check("dataOutB", {8'h00, dataOutB}, {8'h00, mem[10]});
    check("dataOutA2", dataOutA2, {mem2[11], mem2[10]});
    check("dataOutB2", {8'h00, dataOutB2}, 16'h0000);
    results();
  end
endmodule
